// file: rtl/adc_pkg.sv
package adc_pkg;

   // Sample word and bus widths
   localparam int SAMPLE_W = 10;
   localparam int ADDR_W   = 4;
   localparam int DATA_W   = 32;

   // Encode cycles from sample taken to word on the pins
   localparam int PIPE_LATENCY = 5;
   // Flip-flops in each pin synchroniser
   localparam int SYNC_STAGES  = 2;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
   localparam logic [ADDR_W-1:0] MASK_OFS   = 4'h8;
   localparam logic [ADDR_W-1:0] STATE_OFS  = 4'hC;

   // Control register fields and reset value
   localparam int CTRL_HIZ_BIT = 0;
   localparam logic [0:0] CTRL_RESET = 1'h0;

   // Status and mask layout
   localparam int EVT_W          = 3;
   localparam int EVT_SAMPLE_BIT = 0;
   localparam int EVT_RANGE_BIT  = 1;
   localparam int EVT_POWER_BIT  = 2;
   localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;

   // State register fields
   localparam int ST_POWER_LSB = 0;
   localparam int ST_TWOS_BIT  = 4;
   localparam int ST_STAB_BIT  = 5;
   localparam int ST_WORD_LSB  = 16;
   localparam int ST_FLAG_BIT  = 26;

   // Midpoint bit flipped for two's complement
   localparam logic [SAMPLE_W-1:0] MSB_FLIP = 10'h200;

   // Power and drive state, one-hot
   typedef enum logic [3:0] {
      PWR_DRIVE = 4'h1,
      PWR_HIZ   = 4'h2,
      PWR_NAP   = 4'h4,
      PWR_SLEEP = 4'h8
   } pwr_state_t;

   // One conversion result with its range flag
   typedef struct packed {
      logic                range;
      logic [SAMPLE_W-1:0] code;
   } sample_t;

   // All pin inputs that cross into the clock domain
   typedef struct packed {
      logic                enc_pos;
      logic                enc_neg;
      logic                power_down;
      logic                oe_n;
      logic [1:0]          mode;
      logic                over;
      logic                under;
      logic [SAMPLE_W-1:0] code;
   } pins_t;

endpackage

// file: rtl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH  = 1,
   parameter int STAGES = adc_pkg::SYNC_STAGES
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             resetn,
   // Asynchronous in, synchronised out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_q [STAGES];
   logic [WIDTH-1:0] stage_d [STAGES];

   ////////////////////////////////////////////////////////////////////////
   // Shift chain; only the last stage is read outside
   always_comb begin
      stage_d[0] = async_in;
      for (int i = 1; i < STAGES; i++) begin
         stage_d[i] = stage_q[i-1];
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < STAGES; i++) begin
            stage_q[i] <= '0;
         end
      end else begin
         stage_q <= stage_d;
      end
   end

   assign sync_out = stage_q[STAGES-1];

endmodule // pin_sync

// file: rtl/pipe_delay.sv
`timescale 1ns/10ps
module pipe_delay #(
   parameter int DEPTH = adc_pkg::PIPE_LATENCY - 1
) (
   // Clock and reset
   input  wire logic            clock,
   input  wire logic            resetn,
   // Stage control
   input  wire logic            advance,
   input  wire logic            clear,
   // Data
   input  adc_pkg::sample_t     din,
   output adc_pkg::sample_t     dout
);

   adc_pkg::sample_t stage_q [DEPTH];
   adc_pkg::sample_t stage_d [DEPTH];

   ////////////////////////////////////////////////////////////////////////
   // One stage per encode cycle; clear empties every stage at once
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_stage
         always_comb begin
            if (clear) begin
               stage_d[g] = '0;
            end else if (advance) begin
               stage_d[g] = (g == 0) ? din : stage_q[(g == 0) ? 0 : g-1];
            end else begin
               stage_d[g] = stage_q[g];
            end
         end

         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               stage_q[g] <= '0;
            end else begin
               stage_q[g] <= stage_d[g];
            end
         end
      end
   endgenerate

   assign dout = stage_q[DEPTH-1];

endmodule // pipe_delay

// file: rtl/adc_output_interface.sv
`timescale 1ns/10ps
// Summary of operation
// (R1) Sample taken when the positive encode input rises above the negative.
// (R2) Power-down low, enable low: convert and drive the output pins.
// (R3) Power-down low, enable high: keep converting, outputs high impedance.
// (R4) Power-down high, enable low: nap, outputs high impedance.
// (R5) Power-down high, enable high: sleep, outputs high impedance.
// (R6) Capture logic latches word and flag on the data-valid falling edge.
// (R7) Result is a 10-bit word, bit 9 the most significant.
// (R8) Range flag is high when the input went over or under range.
// (R9) Four-level format pin picks binary format and duty stabilizer.
// (R10) Two's complement gives all zeros above and all ones below midpoint; the code flips bit 9, so all zeros at midpoint and all ones one step below.
// (R11) A sample's word leaves five encode cycles after it was taken.
// (R12) Word, flag and data-valid clock update once per encode cycle.
module adc_output_interface #(
   parameter int LATENCY = adc_pkg::PIPE_LATENCY
) (
   // Clock and reset
   input  wire logic                         clock,
   input  wire logic                         resetn,
   // Avalon-MM slave
   input  wire logic [adc_pkg::ADDR_W-1:0]   address,
   input  wire logic                         read,
   input  wire logic                         write,
   input  wire logic [adc_pkg::DATA_W-1:0]   writedata,
   input  wire logic [3:0]                   byteenable,
   output logic      [adc_pkg::DATA_W-1:0]   readdata,
   output logic                              waitrequest,
   output logic                              irq,
   // Encode and select pins
   input  wire logic                         encode_pos_input,
   input  wire logic                         encode_neg_input,
   input  wire logic                         power_down_select,
   input  wire logic                         output_enable_n,
   input  wire logic [1:0]                   mode_level,
   // Quantiser result from the converter core
   input  wire logic [adc_pkg::SAMPLE_W-1:0] core_code,
   input  wire logic                         core_over,
   input  wire logic                         core_under,
   // Output pins, three-state
   output logic      [adc_pkg::SAMPLE_W-1:0] sample_bits_out,
   output logic      [adc_pkg::SAMPLE_W-1:0] sample_bits_oe,
   output logic                              range_exceeded_flag_out,
   output logic                              range_exceeded_flag_oe,
   output logic                              data_valid_clock_out,
   output logic                              data_valid_clock_oe,
   // Duty-cycle stabilizer enable to the clock path
   output logic                              duty_stabilizer_on
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   adc_pkg::pins_t pins_raw;
   adc_pkg::pins_t pins;

   assign pins_raw = '{enc_pos:    encode_pos_input,
                       enc_neg:    encode_neg_input,
                       power_down: power_down_select,
                       oe_n:       output_enable_n,
                       mode:       mode_level,
                       over:       core_over,
                       under:      core_under,
                       code:       core_code};

   pin_sync #(
      .WIDTH  ($bits(adc_pkg::pins_t)),
      .STAGES (adc_pkg::SYNC_STAGES)
   ) u_sync (
      .clock    (clock),
      .resetn   (resetn),
      .async_in (pins_raw),
      .sync_out (pins)
   );

   ////////////////////////////////////////////////////////////////////////
   // Encode edge detection
   logic enc_high;
   logic enc_prev_q;
   logic enc_prev_d;
   logic enc_rise;

   // Encode is high while the positive input sits above the negative
   assign enc_high = pins.enc_pos & ~pins.enc_neg; // R1
   assign enc_rise = enc_high & ~enc_prev_q;        // R1

   always_comb begin
      enc_prev_d = enc_high;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         enc_prev_q <= 1'b0;
      end else begin
         enc_prev_q <= enc_prev_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power and drive state
   adc_pkg::pwr_state_t pwr_q;
   adc_pkg::pwr_state_t pwr_d;
   logic                ctrl_hiz_q;
   logic                ctrl_hiz_d;
   logic                converting;

   // Straps are static; follow them whenever they settle to a new code
   always_comb begin
      case ({pins.power_down, pins.oe_n})
         2'b00:   pwr_d = adc_pkg::PWR_DRIVE; // R2
         2'b01:   pwr_d = adc_pkg::PWR_HIZ;   // R3
         2'b10:   pwr_d = adc_pkg::PWR_NAP;   // R4
         2'b11:   pwr_d = adc_pkg::PWR_SLEEP; // R5
         default: pwr_d = adc_pkg::PWR_SLEEP;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pwr_q <= adc_pkg::PWR_SLEEP;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   // Conversion runs in both normal states, stops in nap and sleep
   assign converting = (pwr_q == adc_pkg::PWR_DRIVE) ||
                       (pwr_q == adc_pkg::PWR_HIZ); // R3

   ////////////////////////////////////////////////////////////////////////
   // Format and stabilizer decode
   logic twos_q;
   logic twos_d;
   logic stab_d;

   always_comb begin
      twos_d = pins.mode[1];                 // R9
      stab_d = pins.mode[1] ^ pins.mode[0];  // R9
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         twos_q             <= 1'b0;
         duty_stabilizer_on <= 1'b0;
      end else begin
         twos_q             <= twos_d;
         duty_stabilizer_on <= stab_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion pipeline: LATENCY stages ahead of the output register,
   // so a sample reaches the pins on the LATENCY-th encode edge after it
   // was taken; one stage fewer would shorten the latency by a cycle
   adc_pkg::sample_t taken;
   adc_pkg::sample_t piped;
   logic             advance;

   assign advance = enc_rise & converting;
   assign taken   = '{range: pins.over | pins.under, // R8
                      code:  pins.code};

   // Sleep loses the pipeline contents, nap only freezes it,
   // so a nap resumes with the words that were still in flight
   pipe_delay #(
      .DEPTH (LATENCY)                             // R11
   ) u_pipe (
      .clock   (clock),
      .resetn  (resetn),
      .advance (advance),                          // R11
      .clear   (pwr_q == adc_pkg::PWR_SLEEP),
      .din     (taken),
      .dout    (piped)
   );

   ////////////////////////////////////////////////////////////////////////
   // Output pin registers
   logic [adc_pkg::SAMPLE_W-1:0] bits_d;
   logic                         flag_d;
   logic                         dvc_d;
   logic                         drive_d;

   always_comb begin
      bits_d  = sample_bits_out;
      flag_d  = range_exceeded_flag_out;
      if (advance) begin
         // Word and flag move together on the same edge
         bits_d = twos_q ? (piped.code ^ adc_pkg::MSB_FLIP) // R10
                         : piped.code;                      // R7
         flag_d = piped.range;                              // R12
      end
      // Rises with new data, so its falling edge sits mid-word
      dvc_d   = enc_high & converting;                      // R12
      drive_d = (pwr_q == adc_pkg::PWR_DRIVE) & ~ctrl_hiz_q; // R2
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sample_bits_out         <= '0;
         range_exceeded_flag_out <= 1'b0;
         data_valid_clock_out    <= 1'b0;
         sample_bits_oe          <= '0;
         range_exceeded_flag_oe  <= 1'b0;
         data_valid_clock_oe     <= 1'b0;
      end else begin
         sample_bits_out         <= bits_d;
         range_exceeded_flag_out <= flag_d;
         data_valid_clock_out    <= dvc_d;
         sample_bits_oe          <= {adc_pkg::SAMPLE_W{drive_d}}; // R4
         range_exceeded_flag_oe  <= drive_d;                      // R5
         data_valid_clock_oe     <= drive_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait cycle, then the answer
   logic                       wait_q;
   logic                       wait_d;
   logic [adc_pkg::DATA_W-1:0] rdata_d;
   logic [adc_pkg::EVT_W-1:0]  status_q;
   logic [adc_pkg::EVT_W-1:0]  status_d;
   logic [adc_pkg::EVT_W-1:0]  mask_q;
   logic [adc_pkg::EVT_W-1:0]  mask_d;
   logic [adc_pkg::EVT_W-1:0]  events;
   logic                       accept;
   logic                       wr_lo;

   assign accept = (read | write) & ~wait_q;
   assign wr_lo  = write & accept & byteenable[0];

   // Events seen at the pins this cycle
   always_comb begin
      events = '0;
      events[adc_pkg::EVT_SAMPLE_BIT] = advance;
      events[adc_pkg::EVT_RANGE_BIT]  = advance & piped.range;
      events[adc_pkg::EVT_POWER_BIT]  = (pwr_d != pwr_q);
   end

   always_comb begin
      wait_d     = ~((read | write) & wait_q);
      ctrl_hiz_d = ctrl_hiz_q;
      mask_d     = mask_q;
      status_d   = status_q;
      rdata_d    = readdata;
      if (wr_lo && address == adc_pkg::CTRL_OFS) begin
         ctrl_hiz_d = writedata[adc_pkg::CTRL_HIZ_BIT];
      end
      if (wr_lo && address == adc_pkg::MASK_OFS) begin
         mask_d = writedata[adc_pkg::EVT_W-1:0];
      end
      // Read clears, but an event in the same cycle still lands
      if (read && accept && address == adc_pkg::STATUS_OFS) begin
         status_d = '0;
      end
      status_d = status_d | events;
      // Data prepared while waitrequest is still high
      if (read && wait_q) begin
         rdata_d = '0;
         case (address)
            adc_pkg::CTRL_OFS: begin
               rdata_d[adc_pkg::CTRL_HIZ_BIT] = ctrl_hiz_q;
            end
            adc_pkg::STATUS_OFS: begin
               rdata_d[adc_pkg::EVT_W-1:0] = status_q | events;
            end
            adc_pkg::MASK_OFS: begin
               rdata_d[adc_pkg::EVT_W-1:0] = mask_q;
            end
            adc_pkg::STATE_OFS: begin
               rdata_d[adc_pkg::ST_POWER_LSB +: 4] = pwr_q;
               rdata_d[adc_pkg::ST_TWOS_BIT]       = twos_q;
               rdata_d[adc_pkg::ST_STAB_BIT]       = duty_stabilizer_on;
               rdata_d[adc_pkg::ST_WORD_LSB +: adc_pkg::SAMPLE_W] =
                  sample_bits_out;
               rdata_d[adc_pkg::ST_FLAG_BIT]       = range_exceeded_flag_out;
            end
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wait_q     <= 1'b1;
         ctrl_hiz_q <= adc_pkg::CTRL_RESET;
         mask_q     <= adc_pkg::MASK_RESET;
         status_q   <= '0;
         readdata   <= '0;
         irq        <= 1'b0;
      end else begin
         wait_q     <= wait_d;
         ctrl_hiz_q <= ctrl_hiz_d;
         mask_q     <= mask_d;
         status_q   <= status_d;
         readdata   <= rdata_d;
         irq        <= |(status_d & mask_d);
      end
   end

   assign waitrequest = wait_q;

endmodule // adc_output_interface

// file: verification/adc_output_interface_asserts.sv
`timescale 1ns/10ps
module adc_output_interface_asserts #(
   parameter int LATENCY = adc_pkg::PIPE_LATENCY
) (
   // Clock and reset
   input wire logic                         clock,
   input wire logic                         resetn,
   // Bus handshake
   input wire logic                         read,
   input wire logic                         write,
   input wire logic                         waitrequest,
   // Pins in
   input wire logic                         encode_pos_input,
   input wire logic                         encode_neg_input,
   input wire logic                         power_down_select,
   input wire logic                         output_enable_n,
   input wire logic [1:0]                   mode_level,
   // Pins out
   input wire logic [adc_pkg::SAMPLE_W-1:0] sample_bits_out,
   input wire logic [adc_pkg::SAMPLE_W-1:0] sample_bits_oe,
   input wire logic                         range_exceeded_flag_out,
   input wire logic                         range_exceeded_flag_oe,
   input wire logic                         data_valid_clock_out,
   input wire logic                         data_valid_clock_oe,
   input wire logic                         duty_stabilizer_on
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);

   // Cycles since reset, saturating; mode decode lags the pin
   logic [2:0] up_q, up_d;
   always_comb up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) up_q <= 3'h0;
      else up_q <= up_d;
   end

   ////////////////////////////////////////////////////////////////////////
   property p_oe_same;
      sample_bits_oe == {adc_pkg::SAMPLE_W{range_exceeded_flag_oe}}
         && data_valid_clock_oe == range_exceeded_flag_oe;
   endproperty
   a_oe_same: assert property (p_oe_same)
      else $error("output enables disagree");
   property p_pd_off;
      power_down_select [*5] |-> !(|sample_bits_oe) && !range_exceeded_flag_oe;
   endproperty
   a_pd_off: assert property (p_pd_off)
      else $error("outputs driven while powered down");
   property p_hiz;
      output_enable_n [*5] |-> !(|sample_bits_oe) && !data_valid_clock_oe;
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("outputs driven with enable high");
   property p_dvc;
      (!power_down_select [*4] ##1 ($rose(encode_pos_input)
         && !encode_neg_input && range_exceeded_flag_oe))
         |-> ##3 $rose(data_valid_clock_out);
   endproperty
   a_dvc: assert property (p_dvc)
      else $error("data valid clock missed encode edge");
   property p_word_hold;
      (range_exceeded_flag_oe && $past(range_exceeded_flag_oe)
         && mode_level == $past(mode_level, 4)
         && $changed({range_exceeded_flag_out, sample_bits_out}))
         |-> $rose(data_valid_clock_out);
   endproperty
   a_word_hold: assert property (p_word_hold)
      else $error("word or flag changed off the valid edge");
   property p_stab;
      (up_q == 3'h7 && $stable(mode_level)) [*5]
         |-> duty_stabilizer_on == (mode_level == 2'h1 || mode_level == 2'h2);
   endproperty
   a_stab: assert property (p_stab)
      else $error("stabilizer decode wrong");
   property p_wait_ans;
      $rose(read || write) |=> !waitrequest;
   endproperty
   a_wait_ans: assert property (p_wait_ans)
      else $error("bus answer late");
   property p_wait_one;
      !waitrequest |=> waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("waitrequest low too long");
endmodule // adc_output_interface_asserts

bind adc_output_interface adc_output_interface_asserts #(
   .LATENCY(LATENCY)) chk (.clock, .resetn, .read, .write, .waitrequest,
   .encode_pos_input, .encode_neg_input, .power_down_select,
   .output_enable_n, .mode_level, .sample_bits_out, .sample_bits_oe,
   .range_exceeded_flag_out, .range_exceeded_flag_oe,
   .data_valid_clock_out, .data_valid_clock_oe, .duty_stabilizer_on);

// file: verification/capture_model.sv
`timescale 1ns/10ps
module capture_model (
   // Pins as seen on the board
   input  wire logic                         data_valid_clock,
   input  wire logic [adc_pkg::SAMPLE_W-1:0] sample_bits,
   input  wire logic                         range_exceeded_flag,
   // Last word taken
   output adc_pkg::sample_t                  captured
);
   initial captured = '0;
   // Falling edge sits mid-word, far from the data change
   always @(negedge data_valid_clock) begin
      captured <= '{range: range_exceeded_flag, code: sample_bits};
   end
endmodule // capture_model

// file: verification/adc_output_interface_tb_top.sv
`timescale 1ns/10ps
module adc_output_interface_tb_top;
   localparam int LAT = adc_pkg::PIPE_LATENCY;
   logic                         clock, resetn, rd, wr, pd, oe_n, ep, en;
   logic                         c_ov, c_un, wq, irq, flag, flag_oe;
   logic                         dv, dv_oe, stab;
   logic [3:0]                   addr, be;
   logic [31:0]                  wdata, rdata;
   logic [1:0]                   mode;
   logic [adc_pkg::SAMPLE_W-1:0] code, bits, bits_oe;
   adc_pkg::sample_t             cap, hist[$];
   int                           n_errors, tests_run, k, chk_from;
   // Released pins show the inverse so stale data never passes
   wire [adc_pkg::SAMPLE_W-1:0] bits_w = bits ^ ~bits_oe;
   wire flag_w = flag ^ ~flag_oe;
   wire dv_w = dv ^ ~dv_oe;

   adc_output_interface #(.LATENCY(LAT)) uut (
      .clock(clock), .resetn(resetn), .address(addr), .read(rd),
      .write(wr), .writedata(wdata), .byteenable(be), .readdata(rdata),
      .waitrequest(wq), .irq(irq), .encode_pos_input(ep),
      .encode_neg_input(en), .power_down_select(pd),
      .output_enable_n(oe_n), .mode_level(mode), .core_code(code),
      .core_over(c_ov), .core_under(c_un), .sample_bits_out(bits),
      .sample_bits_oe(bits_oe), .range_exceeded_flag_out(flag),
      .range_exceeded_flag_oe(flag_oe), .data_valid_clock_out(dv),
      .data_valid_clock_oe(dv_oe), .duty_stabilizer_on(stab));
   capture_model far (.data_valid_clock(dv_w), .sample_bits(bits_w),
      .range_exceeded_flag(flag_w), .captured(cap));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One bus access; waits for the answer under a bound
   task automatic bus(logic w, logic [3:0] a, logic [31:0] d,
         logic [3:0] b, output logic [31:0] q);
      int t;
      rd <= !w; wr <= w; addr <= a; wdata <= d; be <= b;
      t = 0;
      do begin
         @(posedge clock);
         t++;
      end while (wq !== 1'b0 && t < 50);
      q = rdata;
      rd <= 1'b0; wr <= 1'b0;
      check("waitrequest", 0, wq);
      @(posedge clock);
   endtask
   task automatic reg_rd(logic [3:0] a, logic [31:0] m, logic [31:0] e,
         string s);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hF, q);
      check(s, e, q & m);
   endtask
   task automatic reg_wr(logic [3:0] a, logic [31:0] d, logic [3:0] b);
      logic [31:0] q;
      bus(1'b1, a, d, b, q);
   endtask
   // Encode periods of 200 ns; checks the word of the previous period
   task automatic enc(int n);
      adc_pkg::sample_t s;
      repeat (n) begin
         s.code = (k % 4 == 0) ? 10'h200 : (k % 4 == 1) ? 10'h1FF
            : 10'(k * 10'h0B5);
         s.range = (k % 5 == 3) || (k % 7 == 4);
         code <= s.code; c_ov <= k % 5 == 3; c_un <= k % 7 == 4;
         ep <= 1'b0; en <= 1'b1;
         repeat (4) @(posedge clock);
         if (k > chk_from && k > LAT) begin
            s = hist[k - 1 - LAT];
            if (mode[1]) s.code = s.code ^ adc_pkg::MSB_FLIP;
            check("captured", 32'(s), 32'(cap));
         end
         hist.push_back('{range: (k % 5 == 3) || (k % 7 == 4), code: code});
         ep <= 1'b1; en <= 1'b0; k++;
         repeat (4) @(posedge clock);
      end
   endtask
   task automatic summarize();
      $display("Checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Clock and watchdog; whole run needs well under 2000 cycles
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      #(5000 * 25);
      n_errors++;
      summarize();
   end
   initial begin
      resetn = 0; rd = 0; wr = 0; addr = 0; wdata = 0; be = 0; pd = 0;
      oe_n = 0; mode = 0; ep = 0; en = 1; code = 0; c_ov = 0; c_un = 0;
      k = 0; chk_from = 0; n_errors = 0; tests_run = 0;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      reg_rd(adc_pkg::CTRL_OFS, 32'h1, 32'h0, "ctrl reset");
      reg_rd(adc_pkg::MASK_OFS, 32'h7, 32'h0, "mask reset");
      reg_rd(4'h1, 32'hFFFFFFFF, 32'h0, "unmapped");
      for (int m = 0; m < 4; m++) begin
         mode <= 2'(m);
         repeat (6) @(posedge clock);
         reg_rd(adc_pkg::STATE_OFS, 32'h30,
            32'({m == 1 || m == 2, m[1]}) << 4, "format");
         check("stabilizer", m == 1 || m == 2, stab);
      end
      mode <= 2'h0;
      enc(14);
      mode <= 2'h2; chk_from = k + LAT + 1;
      enc(12);
      // Released pins show the inverse to the far side; no word checks
      oe_n <= 1'b1; chk_from = k + 3;
      enc(3);
      check("hiz enables", 0, {bits_oe, flag_oe, dv_oe});
      oe_n <= 1'b0; chk_from = k + 1;
      enc(8);
      reg_wr(adc_pkg::CTRL_OFS, 32'h1, 4'h0);
      reg_rd(adc_pkg::CTRL_OFS, 32'h1, 32'h0, "ctrl no byte");
      reg_wr(adc_pkg::CTRL_OFS, 32'h1, 4'h1);
      // Enables register one edge after the write lands
      @(posedge clock);
      check("forced enables", 0, {bits_oe, flag_oe, dv_oe});
      reg_wr(adc_pkg::CTRL_OFS, 32'h0, 4'h1);
      reg_rd(adc_pkg::STATUS_OFS, 32'h7, 32'h7, "status clear");
      // Strap table: hiz, nap, sleep, drive
      for (int i = 1; i < 5; i++) begin
         {pd, oe_n} <= 2'(i);
         repeat (8) @(posedge clock);
         reg_rd(adc_pkg::STATE_OFS, 32'hF, 32'h1 << (i % 4), "power");
         check("enables", {12{i == 4}}, {bits_oe, flag_oe, dv_oe});
         if (i == 1) begin
            check("irq masked", 0, irq);
            reg_wr(adc_pkg::MASK_OFS, 32'h4, 4'h1);
            check("irq raised", 1, irq);
            reg_rd(adc_pkg::STATUS_OFS, 32'h4, 32'h4, "status power");
            check("irq cleared", 0, irq);
         end
      end
      chk_from = k + LAT + 1;
      enc(10);
      summarize();
   end
endmodule // adc_output_interface_tb_top
